//--- rtl/gic_pkg.sv
// package: register map, field positions, reset values, timing
package gic_pkg;
  // ------------------------------------------------------------
  // register word indices
  // ------------------------------------------------------------
  localparam logic [7:0] A_GLOBAL_MODE_REGISTER = 8'h00;
  localparam logic [7:0] A_GCMD = 8'h01;
  localparam logic [7:0] A_GSTAT = 8'h02;
  localparam logic [7:0] A_CFG_IQ = 8'h03;
  localparam logic [7:0] A_PER_IQ = 8'h04;
  localparam logic [7:0] A_IQLEN1 = 8'h05;
  localparam logic [7:0] A_IQLEN2 = 8'h06;
  localparam logic [5:0] A_RXIQ_HI = 6'h02;
  localparam logic [5:0] A_TXIQ_HI = 6'h03;
  localparam logic [2:0] A_CH_HI = 3'h1;
  localparam logic [5:0] A_BAUD_HI = 6'h10;
  // ------------------------------------------------------------
  // per channel sub-indices
  // ------------------------------------------------------------
  localparam logic [2:0] S_CHCFG = 3'h0;
  localparam logic [2:0] S_FIFO = 3'h1;
  localparam logic [2:0] S_BRX = 3'h2;
  localparam logic [2:0] S_BTX = 3'h3;
  localparam logic [2:0] S_LRX = 3'h4;
  localparam logic [2:0] S_LTX = 3'h5;
  localparam logic [2:0] S_SERIAL_CHANNEL_CONFIG_ZERO = 3'h6;
  localparam logic [2:0] S_SERIAL_CHANNEL_CONFIG_ONE = 3'h7;
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int B_ENDIAN = 0;
  localparam int B_BURST = 1;
  localparam int B_PRIORITY_SCHEME_SELECT = 2;
  localparam int B_CHN = 3;
  localparam int B_PERIPHERAL_PIN_CONFIG = 4;
  localparam int B_LCD = 6;
  localparam int B_DESCRIPTOR_CHAIN_CONTROL = 7;
  localparam int B_AR = 0;
  localparam int B_DONE_IEN = 1;
  localparam int B_DONE = 0;
  localparam int B_ACTIVE = 1;
  localparam int B_DEMUX = 2;
  localparam int B_FAIL = 3;
  localparam int B_RFI = 0;
  localparam int B_TFI = 1;
  localparam int B_RDR = 2;
  localparam int B_RDT = 3;
  localparam int B_PWR = 7;
  localparam int B_RAC = 3;
  // ------------------------------------------------------------
  // reset values and timing
  // ------------------------------------------------------------
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [1:0] PINSET_LBUS = 2'h0;
  localparam int QBUILD_NS = 400;
  localparam int CLK_NS = 100;
  localparam logic [2:0] QBUILD_CYC = 3'((QBUILD_NS + CLK_NS - 1) / CLK_NS);
  localparam int NCH = 4;
endpackage

//--- rtl/gic_bus_if.sv
// interface: register bus between host and controller
`timescale 1ns/100ps
`default_nettype none
interface gic_bus_if;
  logic req;
  logic wr;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic ack;
  logic [31:0] rdata;
  modport dev (input req, input wr, input addr, input wdata, output ack, output rdata);
  modport host (output req, output wr, output addr, output wdata, input ack, input rdata);
endinterface
`default_nettype wire

//--- rtl/gic_dev.sv
// device end: global configuration and initialization logic
// Overview of operation
// RULE_01: strap high means demux bus, low PCI
// RULE_02: PCI reset leaves port as local bus
// RULE_03: before action request, slave accesses only
// RULE_04: host reserves memory before action request
// RULE_05: endian bit selects byte order
// RULE_06: burst bit honoured only in demux mode
// RULE_07: two bits select channel priority scheme
// RULE_08: pin config and width pick pin set
// RULE_09: host sets queue bases, then lengths
// RULE_10: chain bit picks stop flag or compare
// RULE_11: host preps channel before channel config
// RULE_12: power switching keeps registers and state
// RULE_13: powered-down channel: clocks stopped, irqs dropped
// RULE_14: host orders clock, mode, port setup
// RULE_15: action request builds queues, sets done
// RULE_16: host powers channel, receiver off until active
// RULE_17: writes kept while channel powered down
`timescale 1ns/100ps
`default_nettype none
module gic_dev
  import gic_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  gic_bus_if.dev bus,
  input wire logic demux_strap,
  input wire logic [3:0] chan_event,
  input wire logic desc_check,
  input wire logic [1:0] desc_chan,
  input wire logic desc_is_tx,
  input wire logic desc_hold,
  input wire logic [31:0] desc_addr,
  output logic demux_mode_q,
  output logic master_en_q,
  output logic big_endian_q,
  output logic burst_en_q,
  output logic [1:0] prio_sel_q,
  output logic [1:0] pin_set_q,
  output logic bus_width_q,
  output logic irq_q,
  output logic desc_stop_q,
  output logic desc_valid_q,
  output logic [3:0] chan_clk_en_q,
  output logic [3:0] chan_irq_q,
  output logic [3:0] rx_dma_rst_q,
  output logic [3:0] tx_dma_rst_q
);
  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  typedef enum logic [1:0] {Q_IDLE, Q_BUILD, Q_END} gic_qst_t;
  logic ack_q;
  logic [31:0] rdata_q;
  logic [31:0] global_mode_register_q;
  logic ien_q;
  logic done_q;
  logic fail_q;
  logic [31:0] cfgiq_q;
  logic [31:0] periq_q;
  logic [31:0] len1_q;
  logic [31:0] len2_q;
  logic st1_q;
  logic st2_q;
  logic [1:0] strap_cnt_q;
  gic_qst_t qst_q;
  logic [2:0] qcnt_q;
  logic [31:0] ch_rd [0:3];
  logic [31:0] baud_rd [0:3];
  logic [31:0] rxiq_rd [0:3];
  logic [31:0] txiq_rd [0:3];
  logic [31:0] lrx [0:3];
  logic [31:0] ltx [0:3];
  wire take = bus.req & ~ack_q;
  wire wr_take = take & bus.wr;
  wire [7:0] a = bus.addr;
  wire [31:0] wd = bus.wdata;
  wire [1:0] ci = a[1:0];
  wire is_ch = a[7:5] == A_CH_HI;
  wire is_baud = a[7:2] == A_BAUD_HI;
  wire is_rxiq = a[7:2] == A_RXIQ_HI;
  wire is_txiq = a[7:2] == A_TXIQ_HI;
  wire wr_global_mode_register = wr_take & (a == A_GLOBAL_MODE_REGISTER);
  wire wr_gcmd = wr_take & (a == A_GCMD);
  wire wr_gstat = wr_take & (a == A_GSTAT);
  wire ar_hit = wr_gcmd & wd[B_AR] & (qst_q == Q_IDLE);
  wire qlen_ok = (len1_q != RST_WORD) & (len2_q != RST_WORD);
  wire build_end = (qst_q == Q_BUILD) & (qcnt_q == 3'h1);
  wire done_set = build_end & qlen_ok;
  wire done_clr = wr_gstat & wd[B_DONE];
  wire [31:0] stat_word = {28'h0, fail_q, demux_mode_q, master_en_q, done_q};
  // read mux, unmapped words read as zero
  wire [31:0] rd_glob = (a == A_GLOBAL_MODE_REGISTER) ? global_mode_register_q :
                        (a == A_GCMD) ? {30'h0, ien_q, 1'b0} :
                        (a == A_GSTAT) ? stat_word :
                        (a == A_CFG_IQ) ? cfgiq_q :
                        (a == A_PER_IQ) ? periq_q :
                        (a == A_IQLEN1) ? len1_q :
                        (a == A_IQLEN2) ? len2_q : RST_WORD;
  wire [31:0] rd_mux = is_ch ? ch_rd[a[4:3]] :
                       is_baud ? baud_rd[ci] :
                       is_rxiq ? rxiq_rd[ci] :
                       is_txiq ? txiq_rd[ci] : rd_glob;
  wire [31:0] last_sel = desc_is_tx ? ltx[desc_chan] : lrx[desc_chan];
  wire stop_now = global_mode_register_q[B_DESCRIPTOR_CHAIN_CONTROL] ? (desc_addr == last_sel) : desc_hold; // RULE_10
  assign bus.ack = ack_q;
  assign bus.rdata = rdata_q;
  // ------------------------------------------------------------
  // bus answer: one cycle after the request is taken
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ack_q <= 1'b0;
      rdata_q <= RST_WORD;
    end else begin
      ack_q <= take; // RULE_03
      rdata_q <= take ? rd_mux : RST_WORD;
    end
  end
  // ------------------------------------------------------------
  // strap capture
  // ------------------------------------------------------------
  // two flops first, the pin is asynchronous to ref_clk
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st1_q <= 1'b0;
      st2_q <= 1'b0;
    end else begin
      st1_q <= demux_strap;
      st2_q <= st1_q;
    end
  end
  // caught once at edge three, when the sync chain holds the pin; a later strap change is ignored
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      strap_cnt_q <= 2'h0;
      demux_mode_q <= 1'b0;
    end else if (strap_cnt_q != 2'h3) begin
      strap_cnt_q <= strap_cnt_q + 2'h1;
      if (strap_cnt_q == 2'h2) demux_mode_q <= st2_q; // RULE_01
    end
  end
  // ------------------------------------------------------------
  // global registers
  // ------------------------------------------------------------
  // mode word resets to zero: pin set is local bus only
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      global_mode_register_q <= RST_WORD; // RULE_02
      ien_q <= 1'b0;
      cfgiq_q <= RST_WORD;
      periq_q <= RST_WORD;
      len1_q <= RST_WORD;
      len2_q <= RST_WORD;
    end else if (wr_take) begin
      if (wr_global_mode_register) global_mode_register_q <= {24'h0, wd[7:0]};
      if (a == A_GCMD) ien_q <= wd[B_DONE_IEN];
      if (a == A_CFG_IQ) cfgiq_q <= wd;
      if (a == A_PER_IQ) periq_q <= wd;
      if (a == A_IQLEN1) len1_q <= wd;
      if (a == A_IQLEN2) len2_q <= wd;
    end
  end
  // decoded mode outputs, registered so they come from flops
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      big_endian_q <= 1'b0;
      burst_en_q <= 1'b0;
      prio_sel_q <= 2'h0;
      pin_set_q <= PINSET_LBUS;
      bus_width_q <= 1'b0;
    end else begin
      big_endian_q <= global_mode_register_q[B_ENDIAN]; // RULE_05
      burst_en_q <= global_mode_register_q[B_BURST] & demux_mode_q; // RULE_06
      prio_sel_q <= {global_mode_register_q[B_CHN], global_mode_register_q[B_PRIORITY_SCHEME_SELECT]}; // RULE_07
      pin_set_q <= global_mode_register_q[B_PERIPHERAL_PIN_CONFIG+1:B_PERIPHERAL_PIN_CONFIG]; // RULE_08
      bus_width_q <= global_mode_register_q[B_LCD]; // RULE_08
    end
  end
  // ------------------------------------------------------------
  // action request: queue build sequence
  // ------------------------------------------------------------
  // zero queue length counts as a failed setup, no done flag
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      qst_q <= Q_IDLE;
      qcnt_q <= 3'h0;
    end else begin
      case (qst_q)
        Q_IDLE: begin
          if (ar_hit) begin
            qst_q <= Q_BUILD; // RULE_15
            qcnt_q <= QBUILD_CYC;
          end
        end
        Q_BUILD: begin
          qcnt_q <= qcnt_q - 3'h1;
          if (build_end) qst_q <= Q_END;
        end
        Q_END: qst_q <= Q_IDLE;
        default: qst_q <= Q_IDLE;
      endcase
    end
  end
  // done flag: set wins over a write-one clear in the same cycle
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      done_q <= 1'b0;
      fail_q <= 1'b0;
      master_en_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      done_q <= done_set | (done_q & ~done_clr); // RULE_15
      if (build_end) fail_q <= ~qlen_ok;
      if (done_set) master_en_q <= 1'b1; // RULE_03
      irq_q <= (done_set | (done_q & ~done_clr)) & ien_q; // RULE_15
    end
  end
  // descriptor branch check, result one cycle later
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      desc_valid_q <= 1'b0;
      desc_stop_q <= 1'b0;
    end else begin
      desc_valid_q <= desc_check & master_en_q;
      if (desc_check) desc_stop_q <= stop_now; // RULE_10
    end
  end
  // ------------------------------------------------------------
  // per channel registers and power control
  // ------------------------------------------------------------
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    logic [31:0] cr_q [0:7];
    logic [31:0] baud_q;
    logic [31:0] rxiq_q;
    logic [31:0] txiq_q;
    wire sel = wr_take & is_ch & (a[4:3] == 2'(g));
    wire selx = wr_take & (ci == 2'(g));
    wire pwr = cr_q[S_SERIAL_CHANNEL_CONFIG_ZERO][B_PWR];
    wire cfg_wr = sel & (a[2:0] == S_CHCFG);
    assign ch_rd[g] = cr_q[a[2:0]];
    assign baud_rd[g] = baud_q;
    assign rxiq_rd[g] = rxiq_q;
    assign txiq_rd[g] = txiq_q;
    assign lrx[g] = cr_q[S_LRX];
    assign ltx[g] = cr_q[S_LTX];
    // writes land regardless of power state
    always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
        for (int i = 0; i < 8; i++) cr_q[i] <= RST_WORD;
        baud_q <= RST_WORD;
        rxiq_q <= RST_WORD;
        txiq_q <= RST_WORD;
      end else begin
        if (sel) cr_q[a[2:0]] <= wd; // RULE_17
        if (selx & is_baud) baud_q <= wd; // RULE_17
        if (selx & is_rxiq) rxiq_q <= wd;
        if (selx & is_txiq) txiq_q <= wd;
      end
    end
    // power only gates clocks and irqs, state is never cleared
    always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
        chan_clk_en_q[g] <= 1'b0;
        chan_irq_q[g] <= 1'b0;
        rx_dma_rst_q[g] <= 1'b0;
        tx_dma_rst_q[g] <= 1'b0;
      end else begin
        chan_clk_en_q[g] <= pwr; // RULE_13 RULE_12
        chan_irq_q[g] <= chan_event[g] & pwr; // RULE_13
        rx_dma_rst_q[g] <= cfg_wr & wd[B_RDR];
        tx_dma_rst_q[g] <= cfg_wr & wd[B_RDT];
      end
    end
  end
endmodule
`default_nettype wire

//--- rtl/gic_host.sv
// host end: register bus master with setup order guard
`timescale 1ns/100ps
`default_nettype none
module gic_host
  import gic_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  gic_bus_if.host bus,
  input wire logic cmd_valid,
  input wire logic cmd_wr,
  input wire logic [7:0] cmd_addr,
  input wire logic [31:0] cmd_wdata,
  input wire logic mem_ready,
  output logic cmd_ready_q,
  output logic cmd_err_q,
  output logic rd_valid_q,
  output logic [31:0] rd_data_q
);
  // ------------------------------------------------------------
  // order tracking
  // ------------------------------------------------------------
  logic req_q;
  logic wr_q;
  logic [7:0] addr_q;
  logic [31:0] wdata_q;
  logic [1:0] gbase_q;
  logic [1:0] len_q;
  logic active_q;
  logic [3:0] rxb_q;
  logic [3:0] txb_q;
  logic [4:0] prep_q [0:3];
  logic [1:0] ser_q [0:3];
  wire [1:0] ci = cmd_addr[1:0];
  wire [1:0] cc = cmd_addr[4:3];
  wire [2:0] sub = cmd_addr[2:0];
  wire go = cmd_valid & cmd_ready_q;
  wire is_ch = cmd_addr[7:5] == A_CH_HI;
  wire is_baud = cmd_addr[7:2] == A_BAUD_HI;
  wire is_rxiq = cmd_addr[7:2] == A_RXIQ_HI;
  wire is_txiq = cmd_addr[7:2] == A_TXIQ_HI;
  wire bases_ok = (&gbase_q) & (&rxb_q) & (&txb_q);
  wire is_len = (cmd_addr == A_IQLEN1) | (cmd_addr == A_IQLEN2);
  wire bad_len = is_len & ~bases_ok; // RULE_09
  wire bad_ar = (cmd_addr == A_GCMD) & cmd_wdata[B_AR] & ~((&len_q) & mem_ready); // RULE_04 RULE_09
  wire bad_cfg = is_ch & (sub == S_CHCFG) & ~(&prep_q[cc]); // RULE_11
  wire bad_serial_channel_config_zero = is_ch & (sub == S_SERIAL_CHANNEL_CONFIG_ZERO) & ~ser_q[cc][0]; // RULE_14
  wire bad_serial_channel_config_one = is_ch & (sub == S_SERIAL_CHANNEL_CONFIG_ONE) & ~ser_q[cc][1]; // RULE_14
  wire bad_pwr = is_ch & (sub == S_SERIAL_CHANNEL_CONFIG_ZERO) & cmd_wdata[B_PWR] & ~(&len_q); // RULE_16
  wire bad_rac = is_ch & (sub == S_SERIAL_CHANNEL_CONFIG_ONE) & cmd_wdata[B_RAC] & ~active_q; // RULE_16
  wire bad = cmd_wr & (bad_len | bad_ar | bad_cfg | bad_serial_channel_config_zero | bad_serial_channel_config_one | bad_pwr | bad_rac);
  wire wgo = go & cmd_wr & ~bad;
  wire done_rd = bus.ack & ~wr_q & (addr_q == A_GSTAT) & bus.rdata[B_DONE];
  assign bus.req = req_q;
  assign bus.wr = wr_q;
  assign bus.addr = addr_q;
  assign bus.wdata = wdata_q;
  // ------------------------------------------------------------
  // bus master: one access at a time
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      req_q <= 1'b0;
      wr_q <= 1'b0;
      addr_q <= 8'h00;
      wdata_q <= RST_WORD;
      cmd_ready_q <= 1'b1;
      cmd_err_q <= 1'b0;
      rd_valid_q <= 1'b0;
      rd_data_q <= RST_WORD;
    end else begin
      cmd_err_q <= go & bad;
      rd_valid_q <= bus.ack & ~wr_q;
      if (bus.ack & ~wr_q) rd_data_q <= bus.rdata;
      if (go & ~bad) begin
        req_q <= 1'b1;
        cmd_ready_q <= 1'b0;
        wr_q <= cmd_wr;
        addr_q <= cmd_addr;
        wdata_q <= cmd_wdata;
      end else if (bus.ack) begin
        req_q <= 1'b0;
        cmd_ready_q <= 1'b1;
      end
    end
  end
  // global setup progress; active learnt from a status read
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      gbase_q <= 2'h0;
      len_q <= 2'h0;
      active_q <= 1'b0;
    end else begin
      if (wgo & (cmd_addr == A_CFG_IQ)) gbase_q[0] <= 1'b1;
      if (wgo & (cmd_addr == A_PER_IQ)) gbase_q[1] <= 1'b1;
      if (wgo & (cmd_addr == A_IQLEN1)) len_q[0] <= 1'b1;
      if (wgo & (cmd_addr == A_IQLEN2)) len_q[1] <= 1'b1;
      if (done_rd) active_q <= 1'b1; // RULE_16
    end
  end
  // ------------------------------------------------------------
  // per channel progress
  // ------------------------------------------------------------
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    wire own = wgo & is_ch & (cc == 2'(g));
    always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
        rxb_q[g] <= 1'b0;
        txb_q[g] <= 1'b0;
        prep_q[g] <= 5'h00;
        ser_q[g] <= 2'h0;
      end else begin
        if (wgo & is_rxiq & (ci == 2'(g))) rxb_q[g] <= 1'b1;
        if (wgo & is_txiq & (ci == 2'(g))) txb_q[g] <= 1'b1;
        if (wgo & is_baud & (ci == 2'(g))) ser_q[g][0] <= 1'b1; // RULE_14
        if (own & (sub == S_SERIAL_CHANNEL_CONFIG_ZERO)) ser_q[g][1] <= 1'b1; // RULE_14
        if (own & (sub >= S_FIFO) & (sub <= S_LTX)) prep_q[g][3'(sub - S_FIFO)] <= 1'b1; // RULE_11
      end
    end
  end
endmodule
`default_nettype wire

//--- bench/gic_bus_asserts.sv
// checker: register bus handshake between host end and device end
`timescale 1ns/100ps
`default_nettype none
module gic_bus_asserts (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic req,
  input wire logic wr,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic ack,
  input wire logic [31:0] rdata
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // ----------------------------------------
  // request taken and answered
  // ----------------------------------------
  sequence s_take;
    req && !ack;
  endsequence
  sequence s_answer;
    ack ##1 (!req && !ack);
  endsequence
  property p_walk;
    s_take |=> s_answer;
  endproperty
  a_walk: assert property (p_walk) else $error("bus answer late or request kept");
  property p_req_hold;
    s_take |=> req && $stable(wr) && $stable(addr) && $stable(wdata);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request changed before answer");
  // answer only for a request, and only once
  property p_ack_cause;
    !req |=> !ack;
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("answer without request");
  property p_ack_with_req;
    ack |-> req;
  endproperty
  a_ack_with_req: assert property (p_ack_with_req) else $error("answer after request dropped");
  property p_ack_gap;
    ack |=> !ack [*2];
  endproperty
  a_ack_gap: assert property (p_ack_gap) else $error("answers closer than three cycles");
  // read data is zero outside the answer cycle
  property p_rdata_idle;
    !ack |-> rdata == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside answer");
  property p_req_gap;
    $fell(req) |-> !ack ##1 !ack;
  endproperty
  a_req_gap: assert property (p_req_gap) else $error("answer after request released");
  // first edge after reset: no bus activity yet
  property p_quiet;
    $rose(rstn) |-> !req && !ack;
  endproperty
  a_quiet: assert property (p_quiet) else $error("bus busy at reset release");
endmodule
`default_nettype wire

//--- bench/tb.sv
// testbench: host and device ends joined, driven from the command side
`timescale 1ns/100ps
`default_nettype none
module tb;
  import gic_pkg::*;
  logic ref_clk, rstn, strap, cmd_valid, cmd_wr, mem_ready, desc_check, desc_is_tx, desc_hold;
  logic [7:0] cmd_addr;
  logic [31:0] cmd_wdata, desc_addr, rd_data_q, m, b;
  logic [3:0] chan_event, chan_clk_en_q, chan_irq_q, rx_dma_rst_q, tx_dma_rst_q;
  logic [1:0] desc_chan, prio_sel_q, pin_set_q, rst_seen;
  logic cmd_ready_q, cmd_err_q, rd_valid_q, demux_mode_q, master_en_q, big_endian_q, burst_en_q;
  logic bus_width_q, irq_q, desc_stop_q, desc_valid_q, irq_seen, dv_seen, ds_seen;
  logic [32:0] exp_q[$];
  int err_total, cmp_count;
  gic_bus_if u_gic_bus_if();
  gic_host u_gic_host(.ref_clk(ref_clk), .rstn(rstn), .bus(u_gic_bus_if.host), .cmd_valid(cmd_valid),
    .cmd_wr(cmd_wr), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .mem_ready(mem_ready),
    .cmd_ready_q(cmd_ready_q), .cmd_err_q(cmd_err_q), .rd_valid_q(rd_valid_q), .rd_data_q(rd_data_q));
  gic_dev u_gic_dev(.ref_clk(ref_clk), .rstn(rstn), .bus(u_gic_bus_if.dev), .demux_strap(strap),
    .chan_event(chan_event), .desc_check(desc_check), .desc_chan(desc_chan), .desc_is_tx(desc_is_tx),
    .desc_hold(desc_hold), .desc_addr(desc_addr), .demux_mode_q(demux_mode_q), .master_en_q(master_en_q),
    .big_endian_q(big_endian_q), .burst_en_q(burst_en_q), .prio_sel_q(prio_sel_q), .pin_set_q(pin_set_q),
    .bus_width_q(bus_width_q), .irq_q(irq_q), .desc_stop_q(desc_stop_q), .desc_valid_q(desc_valid_q),
    .chan_clk_en_q(chan_clk_en_q), .chan_irq_q(chan_irq_q), .rx_dma_rst_q(rx_dma_rst_q),
    .tx_dma_rst_q(tx_dma_rst_q));
  gic_bus_asserts u_gic_bus_asserts(.ref_clk(ref_clk), .rstn(rstn), .req(u_gic_bus_if.req),
    .wr(u_gic_bus_if.wr), .addr(u_gic_bus_if.addr), .wdata(u_gic_bus_if.wdata), .ack(u_gic_bus_if.ack),
    .rdata(u_gic_bus_if.rdata));
  // ----------------------------------------
  // clock, sticky pulse catchers, timeout
  // ----------------------------------------
  initial begin
    ref_clk = 0;
    forever #50 ref_clk = ~ref_clk;
  end
  // pulses are caught at the edge so their exact cycle does not matter
  always @(posedge ref_clk) begin
    if (chan_irq_q[0] === 1'b1) irq_seen <= 1;
    if (rx_dma_rst_q[0] === 1'b1) rst_seen[0] <= 1;
    if (tx_dma_rst_q[0] === 1'b1) rst_seen[1] <= 1;
    if (desc_valid_q === 1'b1) begin
      dv_seen <= 1;
      ds_seen <= desc_stop_q;
    end
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    give_verdict();
  end
  // ----------------------------------------
  // compare, verdict, result monitor
  // ----------------------------------------
  task automatic check(input string name, input logic [32:0] seen, input logic [32:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // oldest note is matched against each refusal or read result
  always @(negedge ref_clk) begin
    if (cmd_err_q === 1'b1 || rd_valid_q === 1'b1) begin
      if (exp_q.size() == 0) begin
        check("unexpected result", 1, 0);
      end else begin
        check("result", cmd_err_q === 1'b1 ? {1'b1, 32'h0} : {1'b0, rd_data_q}, exp_q.pop_front());
      end
    end
  end
  // ----------------------------------------
  // drivers
  // ----------------------------------------
  task automatic wait_ready();
    for (int n = 0; n < 50 && cmd_ready_q !== 1'b1; n++) @(negedge ref_clk);
    if (cmd_ready_q !== 1'b1) begin
      err_total++;
      give_verdict();
    end
  endtask
  // note: 0 nothing shows, 1 refused, 2 read returns d
  task automatic cmd(input logic w, input logic [7:0] a, input logic [31:0] d, input int note);
    wait_ready();
    if (note == 1) exp_q.push_back({1'b1, 32'h0});
    if (note == 2) exp_q.push_back({1'b0, d});
    cmd_valid = 1;
    cmd_wr = w;
    cmd_addr = a;
    cmd_wdata = w ? d : $urandom;
    @(negedge ref_clk);
    cmd_valid = 0;
    repeat (2) @(negedge ref_clk);
    wait_ready();
  endtask
  task automatic do_reset(input logic s);
    rstn = 0;
    strap = s;
    repeat (6) @(negedge ref_clk);
    rstn = 1;
    repeat (4) @(negedge ref_clk);
    check("demux mode", demux_mode_q, s);
    check("pin set", pin_set_q, PINSET_LBUS);
    check("master", master_en_q, 0);
  endtask
  task automatic mode_sweep(input logic dm);
    for (int i = 0; i < 4; i++) begin
      m = ($urandom & 32'hcf) | (32'(i) << B_PERIPHERAL_PIN_CONFIG);
      cmd(1, A_GLOBAL_MODE_REGISTER, m, 0);
      check("endian", big_endian_q, m[B_ENDIAN]);
      check("burst", burst_en_q, m[B_BURST] & dm);
      check("priority", prio_sel_q, {m[B_CHN], m[B_PRIORITY_SCHEME_SELECT]});
      check("pin set", pin_set_q, m[5:4]);
      check("bus width", bus_width_q, m[B_LCD]);
    end
  endtask
  task automatic pulse_event();
    irq_seen = 0;
    chan_event = 4'h1;
    @(negedge ref_clk);
    chan_event = 4'h0;
    repeat (3) @(negedge ref_clk);
  endtask
  task automatic desc(input logic t, input logic h, input logic [31:0] a);
    dv_seen = 0;
    desc_check = 1;
    desc_is_tx = t;
    desc_hold = h;
    desc_addr = a;
    @(negedge ref_clk);
    desc_check = 0;
    repeat (3) @(negedge ref_clk);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {cmd_valid, cmd_wr, mem_ready, desc_check, desc_is_tx, desc_hold, irq_seen, dv_seen, ds_seen} = '0;
    {cmd_addr, cmd_wdata, desc_addr, chan_event, desc_chan, rst_seen} = '0;
    err_total = 0;
    cmp_count = 0;
    b = $urandom(32'h7280);
    do_reset(1);
    mode_sweep(1);
    cmd(1, A_IQLEN1, 32'h10, 1);
    cmd(1, A_CFG_IQ, $urandom, 0);
    cmd(1, A_PER_IQ, $urandom, 0);
    for (int c = 0; c < NCH; c++) begin
      cmd(1, {A_RXIQ_HI, 2'(c)}, $urandom, 0);
      cmd(1, {A_TXIQ_HI, 2'(c)}, $urandom, 0);
    end
    cmd(1, A_GCMD, 32'h3, 1);
    cmd(1, A_IQLEN1, 32'h10, 0);
    cmd(1, A_IQLEN2, 32'h10, 0);
    cmd(1, A_GCMD, 32'h3, 1);
    cmd(1, 8'h20, 32'hf, 1);
    cmd(1, 8'h27, 32'h0, 1);
    cmd(1, 8'h26, 32'h5, 1);
    for (int s = 1; s < 6; s++) cmd(1, {A_CH_HI, 2'd0, 3'(s)}, 32'h1000 * s, 0);
    cmd(1, 8'h20, 32'hf, 0);
    check("dma resets", rst_seen, 2'b11);
    b = $urandom & 32'hff;
    cmd(1, {A_BAUD_HI, 2'd0}, b, 0);
    cmd(1, 8'h26, 32'h5, 0);
    cmd(0, 8'h26, 32'h5, 2);
    pulse_event();
    check("irq while down", irq_seen, 0);
    check("clock while down", chan_clk_en_q[0], 0);
    cmd(1, 8'h27, 32'h8, 1);
    desc(0, 1, 32'h0);
    check("desc before active", dv_seen, 0);
    mem_ready = 1;
    cmd(1, A_GCMD, 32'h3, 0);
    repeat (QBUILD_CYC + 2) @(negedge ref_clk);
    check("irq on done", irq_q, 1);
    check("master on", master_en_q, 1);
    cmd(0, A_GSTAT, 32'h7, 2);
    cmd(1, A_GSTAT, 32'h1, 0);
    check("irq cleared", irq_q, 0);
    cmd(1, 8'h27, 32'h8, 0);
    cmd(1, 8'h26, 32'h85, 0);
    check("clock on", chan_clk_en_q[0], 1);
    pulse_event();
    check("irq powered", irq_seen, 1);
    cmd(1, 8'h26, 32'h5, 0);
    cmd(0, {A_BAUD_HI, 2'd0}, b, 2);
    cmd(0, 8'h26, 32'h5, 2);
    cmd(1, A_GLOBAL_MODE_REGISTER, 32'h0, 0);
    desc(0, 1, 32'h0);
    check("stop on hold", {dv_seen, ds_seen}, 2'b11);
    desc(0, 0, 32'h4000);
    check("run on clear", {dv_seen, ds_seen}, 2'b10);
    cmd(1, A_GLOBAL_MODE_REGISTER, 32'h80, 0);
    desc(0, 0, 32'h4000);
    check("stop at last rx", {dv_seen, ds_seen}, 2'b11);
    desc(1, 1, 32'h4004);
    check("run past tx", {dv_seen, ds_seen}, 2'b10);
    desc(1, 0, 32'h5000);
    check("stop at last tx", {dv_seen, ds_seen}, 2'b11);
    do_reset(0);
    mode_sweep(0);
    check("pending results", exp_q.size(), 0);
    give_verdict();
  end
endmodule
`default_nettype wire
